// >>> audio_port_pkg.sv
// Register map, field positions and limits of the serial audio port
`default_nettype none
package audio_port_pkg;
    // Register byte addresses on the peripheral bus
    localparam logic [31:0] ADDR_ID = 32'hbfe60000;
    localparam logic [31:0] ADDR_CFG = 32'hbfe60004;
    localparam logic [31:0] ADDR_CTL = 32'hbfe60008;
    localparam logic [31:0] ADDR_RXD = 32'hbfe6000c;
    localparam logic [31:0] ADDR_TXD = 32'hbfe60010;
    // Reset value shared by every register
    localparam logic [31:0] REG_RESET = 32'h00000000;
    // Control bit positions
    localparam int CTL_MASTER = 15;
    localparam int CTL_MSB_LEFT = 14;
    localparam int CTL_RX_EN = 13;
    localparam int CTL_TX_EN = 12;
    localparam int CTL_RX_DMA = 11;
    localparam int CTL_TX_DMA = 7;
    localparam int CTL_RX_INT = 1;
    localparam int CTL_TX_INT = 0;
    // Writable bits; reserved bits read as zero
    localparam logic [31:0] CTL_MASK = 32'h0000f883;
    localparam logic [31:0] ID_MASK = 32'h0000033f;
    // Configuration field low bits, each field eight bits wide
    localparam int CFG_SLOT_LSB = 24;
    localparam int CFG_DEPTH_LSB = 16;
    localparam int CFG_BDIV_LSB = 8;
    localparam int CFG_MDIV_LSB = 0;
    // Legal sample and slot lengths
    localparam logic [5:0] LEN_MIN = 6'h08;
    localparam logic [5:0] LEN_MAX = 6'h20;
    // Buffer depth in 32-bit words: 8 bytes
    localparam int FIFO_WORDS = 2;
endpackage
`default_nettype wire

// >>> audio_fifo.sv
// Small word buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module audio_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = audio_port_pkg::FIFO_WORDS
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    // Pointers wrap naturally, so the depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("audio_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    // Honest full and empty from the fill count
    assign o_in_ready = (count_reg != FULL_COUNT);
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = mem[rd_ptr_reg];

    // Storage is written without reset
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + PW'(push);
            rd_ptr_reg <= rd_ptr_reg + PW'(pop);
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end
endmodule
`default_nettype wire

// >>> audio_port.sv
// Master serial audio port with register file, clock dividers and buffers
`timescale 1ns/100ps
`default_nettype none
module audio_port #(
    parameter int DATA_W = 32,
    parameter int FIFO_DEPTH = audio_port_pkg::FIFO_WORDS
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_mclk,
    output logic o_bclk,
    output logic o_ws,
    output logic o_sdata,
    input wire logic i_sdata,
    output logic o_irq,
    output logic o_tx_dma_req,
    output logic o_rx_dma_req
);
    // Data path is built for one 32-bit word per bus access
    if (DATA_W != 32 || FIFO_DEPTH < 2) begin : g_param_check
        $error("audio_port: DATA_W must be 32 and FIFO_DEPTH at least 2");
    end

    // Bring a length field into the legal 8..32 range
    function automatic logic [5:0] clamp_len(input logic [7:0] f);
        if (f < 8'(audio_port_pkg::LEN_MIN)) return audio_port_pkg::LEN_MIN;
        if (f > 8'(audio_port_pkg::LEN_MAX)) return audio_port_pkg::LEN_MAX;
        return f[5:0];
    endfunction

    // Place a right-justified sample into an MSB-first slot image
    function automatic logic [31:0] to_slot(input logic [31:0] w, input logic [5:0] d,
                                            input logic [5:0] l, input logic left);
        logic [31:0] msb;
        msb = w << (6'h20 - d);
        if (!left && l > d) return msb >> (l - d);
        return msb;
    endfunction

    // Recover a right-justified sample from a received slot image
    function automatic logic [31:0] from_slot(input logic [31:0] img, input logic [5:0] d,
                                              input logic [5:0] l, input logic left);
        logic [31:0] msb;
        msb = (!left && l > d) ? (img << (l - d)) : img;
        return msb >> (6'h20 - d);
    endfunction

    logic [31:0] id_reg;
    logic [31:0] cfg_reg;
    logic [31:0] ctl_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [7:0] mdiv_reg;
    logic mclk_reg;
    logic [7:0] bdiv_reg;
    logic bclk_reg;
    logic [5:0] slot_bit_reg;
    logic ws_reg;
    logic [31:0] tx_sh_reg;
    logic [31:0] rx_sh_reg;
    logic rx_armed_reg;
    logic irq_reg;
    logic tx_dma_reg;
    logic rx_dma_reg;

    // Configuration and control decode
    wire [5:0] slot_len = clamp_len(cfg_reg[audio_port_pkg::CFG_SLOT_LSB +: 8]);
    wire [5:0] depth = clamp_len(cfg_reg[audio_port_pkg::CFG_DEPTH_LSB +: 8]);
    wire [7:0] bit_ratio = cfg_reg[audio_port_pkg::CFG_BDIV_LSB +: 8];
    wire [7:0] sys_ratio = cfg_reg[audio_port_pkg::CFG_MDIV_LSB +: 8];
    wire master = ctl_reg[audio_port_pkg::CTL_MASTER];
    wire msb_left = ctl_reg[audio_port_pkg::CTL_MSB_LEFT];
    wire rx_on = ctl_reg[audio_port_pkg::CTL_RX_EN];
    wire tx_on = ctl_reg[audio_port_pkg::CTL_TX_EN];
    wire run = master && (rx_on || tx_on);

    // Bit clock edge enables and slot position
    wire b_term = run && (bdiv_reg == bit_ratio);
    wire fall_en = b_term && bclk_reg;
    wire rise_en = b_term && !bclk_reg;
    wire slot_last = (slot_bit_reg == slot_len - 6'h01);
    wire slot_first = (slot_bit_reg == 6'h00);

    // Buffer handshakes
    logic tx_in_ready;
    logic tx_out_valid;
    logic [31:0] tx_out_data;
    logic rx_in_ready;
    logic rx_out_valid;
    logic [31:0] rx_out_data;

    // Bus decode: one wait state per access, transmit writes wait for room
    wire hit_id = (i_paddr == audio_port_pkg::ADDR_ID);
    wire hit_cfg = (i_paddr == audio_port_pkg::ADDR_CFG);
    wire hit_ctl = (i_paddr == audio_port_pkg::ADDR_CTL);
    wire hit_rxd = (i_paddr == audio_port_pkg::ADDR_RXD);
    wire hit_txd = (i_paddr == audio_port_pkg::ADDR_TXD);
    wire hit_any = hit_id || hit_cfg || hit_ctl || hit_rxd || hit_txd;
    wire access = i_psel && i_penable && !pready_reg;
    wire tx_stall = i_pwrite && hit_txd && !tx_in_ready;
    wire done = access && !tx_stall;
    wire wr_done = done && i_pwrite;
    wire rd_done = done && !i_pwrite;
    wire tx_push = wr_done && hit_txd;
    wire rx_pop = rd_done && hit_rxd && rx_out_valid;

    // Read data selection; empty receive buffer reads zero
    wire [31:0] rx_word = rx_out_valid ? rx_out_data : 32'h00000000;
    wire [31:0] rd_mux = hit_id ? (id_reg & audio_port_pkg::ID_MASK) :
                         hit_cfg ? cfg_reg :
                         hit_ctl ? (ctl_reg & audio_port_pkg::CTL_MASK) :
                         hit_rxd ? rx_word : 32'h00000000;

    // Link data path: slot images and buffer strobes
    wire tx_pop = fall_en && slot_first && tx_on;
    wire [31:0] tx_img = (tx_on && tx_out_valid) ?
                         to_slot(tx_out_data, depth, slot_len, msb_left) : 32'h00000000;
    wire [31:0] rx_full_sh = {rx_sh_reg[30:0], i_sdata};
    wire [31:0] rx_img = rx_full_sh << (6'h20 - slot_len);
    wire rx_push = rise_en && slot_first && rx_on && rx_armed_reg;
    wire [31:0] rx_sample = from_slot(rx_img, depth, slot_len, msb_left);

    // Service requests for interrupt and DMA
    wire irq_next = (ctl_reg[audio_port_pkg::CTL_RX_INT] && !rx_out_valid) ||
                    (ctl_reg[audio_port_pkg::CTL_TX_INT] && !tx_in_ready);
    wire tx_dma_next = ctl_reg[audio_port_pkg::CTL_TX_DMA] && tx_on && tx_in_ready;
    wire rx_dma_next = ctl_reg[audio_port_pkg::CTL_RX_DMA] && rx_on && rx_out_valid;

    // Transmit and receive buffers, eight bytes each
    audio_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_in_valid(tx_push),
        .o_in_ready(tx_in_ready),
        .i_in_data(i_pwdata),
        .o_out_valid(tx_out_valid),
        .i_out_ready(tx_pop),
        .o_out_data(tx_out_data)
    );
    audio_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .i_clock(i_clock),
        .i_arst_n(i_arst_n),
        .i_in_valid(rx_push),
        .o_in_ready(rx_in_ready),
        .i_in_data(rx_sample),
        .o_out_valid(rx_out_valid),
        .i_out_ready(rx_pop),
        .o_out_data(rx_out_data)
    );

    // Bus answer flops
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= audio_port_pkg::REG_RESET;
        end else begin
            pready_reg <= done;
            pslverr_reg <= done && !hit_any;
            prdata_reg <= rd_done ? rd_mux : 32'h00000000;
        end
    end

    // Register writes
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            id_reg <= audio_port_pkg::REG_RESET;
            cfg_reg <= audio_port_pkg::REG_RESET;
            ctl_reg <= audio_port_pkg::REG_RESET;
        end else if (wr_done) begin
            if (hit_id) id_reg <= i_pwdata & audio_port_pkg::ID_MASK;
            if (hit_cfg) cfg_reg <= i_pwdata;
            if (hit_ctl) ctl_reg <= i_pwdata & audio_port_pkg::CTL_MASK;
        end
    end

    // System clock divider: toggles every ratio+1 bus clocks
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mdiv_reg <= 8'h00;
            mclk_reg <= 1'b0;
        end else if (!master) begin
            mdiv_reg <= 8'h00;
            mclk_reg <= 1'b0;
        end else if (mdiv_reg == sys_ratio) begin
            mdiv_reg <= 8'h00;
            mclk_reg <= !mclk_reg;
        end else begin
            mdiv_reg <= mdiv_reg + 8'h01;
        end
    end

    // Bit clock divider, slot counter and word select
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bdiv_reg <= 8'h00;
            bclk_reg <= 1'b0;
            slot_bit_reg <= 6'h00;
            ws_reg <= 1'b1;
        end else if (!run) begin
            bdiv_reg <= 8'h00;
            bclk_reg <= 1'b0;
            slot_bit_reg <= slot_len - 6'h01;
            ws_reg <= 1'b1;
        end else begin
            bdiv_reg <= b_term ? 8'h00 : bdiv_reg + 8'h01;
            if (b_term) bclk_reg <= !bclk_reg;
            if (fall_en) begin
                slot_bit_reg <= slot_last ? 6'h00 : slot_bit_reg + 6'h01;
                if (slot_last) ws_reg <= !ws_reg;
            end
        end
    end

    // Transmit shifter: loads one bit clock after the select change
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tx_sh_reg <= 32'h00000000;
        end else if (!run) begin
            tx_sh_reg <= 32'h00000000;
        end else if (fall_en) begin
            tx_sh_reg <= slot_first ? tx_img : (tx_sh_reg << 1);
        end
    end

    // Receive shifter samples on bit clock rising edges
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_sh_reg <= 32'h00000000;
            rx_armed_reg <= 1'b0;
        end else if (!run) begin
            rx_sh_reg <= 32'h00000000;
            rx_armed_reg <= 1'b0;
        end else if (rise_en && rx_on) begin
            rx_sh_reg <= rx_full_sh;
            if (slot_bit_reg == 6'h01) rx_armed_reg <= 1'b1;
        end
    end

    // Service request flops
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_reg <= 1'b0;
            tx_dma_reg <= 1'b0;
            rx_dma_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
            tx_dma_reg <= tx_dma_next;
            rx_dma_reg <= rx_dma_next;
        end
    end

    // Outputs straight from flops
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_mclk = mclk_reg;
    assign o_bclk = bclk_reg;
    assign o_ws = ws_reg;
    assign o_sdata = tx_sh_reg[31];
    assign o_irq = irq_reg;
    assign o_tx_dma_req = tx_dma_reg;
    assign o_rx_dma_req = rx_dma_reg;

    // Checks on the clocks, the data path, the service requests and the bus answer
    ws_toggle_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (fall_en && slot_last) |=> (o_ws != $past(o_ws)))
        else $error("word select did not toggle at slot end");
    ws_hold_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (run && !(fall_en && slot_last)) |=> $stable(o_ws))
        else $error("word select changed inside a slot");
    bclk_div_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (run && $changed(o_bclk)) |-> $past(bdiv_reg == bit_ratio))
        else $error("bit clock edge off divider terminal");
    mclk_div_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (master && $past(master) && $changed(o_mclk)) |-> $past(mdiv_reg == sys_ratio))
        else $error("system clock edge off divider terminal");
    msb_first_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (fall_en && slot_first) |=> (o_sdata == $past(tx_img[31])))
        else $error("first data bit is not the slot MSB");
    pad_zero_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (msb_left && depth < slot_len) |-> ((tx_img << depth) == 32'h00000000))
        else $error("transmit low bits not padded with zero");
    bclk_idle_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        !run |=> (!o_bclk && o_ws))
        else $error("bit clock not parked while idle");
    tx_off_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (run && !tx_on && fall_en && slot_first) |=> !o_sdata)
        else $error("data sent while transmitter disabled");
    rx_gate_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        rx_push |-> (rx_on && rise_en))
        else $error("receive push without enable");
    irq_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        (ctl_reg[audio_port_pkg::CTL_RX_INT] && !rx_out_valid) |=> o_irq)
        else $error("receive empty interrupt missing");
    dma_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        o_tx_dma_req |-> $past(ctl_reg[audio_port_pkg::CTL_TX_DMA]))
        else $error("transmit DMA request without enable");
    bus_wait_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
        o_pready |=> !o_pready)
        else $error("bus ready held longer than one cycle");

    // Main scenarios
    ws_cover_c: cover property (@(posedge i_clock) disable iff (!i_arst_n)
        $rose(o_ws) ##[1:1000] $fell(o_ws));
    tx_cover_c: cover property (@(posedge i_clock) disable iff (!i_arst_n) tx_pop && tx_out_valid);
    rx_cover_c: cover property (@(posedge i_clock) disable iff (!i_arst_n) rx_push && rx_in_ready);
    err_cover_c: cover property (@(posedge i_clock) disable iff (!i_arst_n) o_pready && o_pslverr);
endmodule
`default_nettype wire

// >>> codec_model.sv
// Behavioural model of the external codec on the serial audio link
`timescale 1ns/100ps
`default_nettype none
module codec_model #(
    parameter logic [7:0] LEFT_WORD = 8'ha5,
    parameter logic [7:0] RIGHT_WORD = 8'h5a
) (
    input wire logic i_arst_n,
    input wire logic i_bclk,
    input wire logic i_ws,
    input wire logic i_sdata,
    output logic o_sdata,
    output logic [31:0] o_left_word,
    output logic [31:0] o_right_word,
    output logic [7:0] o_words
);
    logic [31:0] shift_reg;
    logic [7:0] out_reg;
    logic rise_ws_reg;
    logic fall_ws_reg;

    // Capture at bit clock rise; a select change closes the slot with its LSB
    always_ff @(posedge i_bclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shift_reg <= 32'h0;
            o_left_word <= 32'h0;
            o_right_word <= 32'h0;
            o_words <= 8'h00;
            rise_ws_reg <= 1'b1;
        end else if (i_ws != rise_ws_reg) begin
            if (rise_ws_reg) begin
                o_right_word <= {shift_reg[30:0], i_sdata};
            end else begin
                o_left_word <= {shift_reg[30:0], i_sdata};
            end
            shift_reg <= 32'h0;
            o_words <= o_words + 8'h01;
            rise_ws_reg <= i_ws;
        end else begin
            shift_reg <= {shift_reg[30:0], i_sdata};
        end
    end

    // Launch at bit clock fall; MSB leaves on the fall after the select change
    always_ff @(negedge i_bclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_reg <= 8'h55;
            fall_ws_reg <= 1'b1;
        end else if (rise_ws_reg != fall_ws_reg) begin // Select taken at the rise, no race
            out_reg <= rise_ws_reg ? RIGHT_WORD : LEFT_WORD;
            fall_ws_reg <= rise_ws_reg;
        end else begin
            out_reg <= {out_reg[6:0], ~out_reg[7]}; // Past the LSB, bits keep changing
        end
    end
    assign o_sdata = out_reg[7];
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the serial audio port
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic mclk, bclk, ws, sdata_out, sdata_in, irq, tx_dma, rx_dma;
    logic [31:0] paddr, pwdata, prdata, rd, left_word, right_word;
    logic [7:0] words;
    int miscompares = 0;
    int comparisons = 0;

    audio_port i_dut (.i_clock(clock), .i_arst_n(arst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_mclk(mclk),
        .o_bclk(bclk), .o_ws(ws), .o_sdata(sdata_out), .i_sdata(sdata_in), .o_irq(irq),
        .o_tx_dma_req(tx_dma), .o_rx_dma_req(rx_dma));
    codec_model i_codec (.i_arst_n(arst_n), .i_bclk(bclk), .i_ws(ws),
        .i_sdata(sdata_out), .o_sdata(sdata_in), .o_left_word(left_word),
        .o_right_word(right_word), .o_words(words));

    // Bus clock, 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout();
        check(32'h0, 32'h1);
        report_and_stop();
    endtask

    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (10) @(posedge clock);
        arst_n <= 1'b1;
    endtask

    // One bus transfer: setup, access, then wait for ready under a bound
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reset values, masks and an unmapped address
    task automatic t_regs();
        logic [31:0] a [5];
        a = '{audio_port_pkg::ADDR_ID, audio_port_pkg::ADDR_CFG, audio_port_pkg::ADDR_CTL,
            audio_port_pkg::ADDR_RXD, audio_port_pkg::ADDR_TXD};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, a[i], 32'h0);
            check(rd, 32'h00000000);
        end
        apb(1'b0, 32'hbfe60014, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, audio_port_pkg::ADDR_ID, 32'hffffffff);
        apb(1'b0, audio_port_pkg::ADDR_ID, 32'h0);
        check(rd, 32'h0000033f);
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'hffffffff);
        apb(1'b0, audio_port_pkg::ADDR_CTL, 32'h0);
        check(rd, 32'h0000f883);
        apb(1'b1, audio_port_pkg::ADDR_CFG, 32'h20100a07);
        apb(1'b0, audio_port_pkg::ADDR_CFG, 32'h0);
        check(rd, 32'h20100a07);
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'h0);
    endtask

    // Interrupt on empty receive and full transmit buffers
    task automatic t_irq();
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'h00000002);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'h00000001);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        apb(1'b1, audio_port_pkg::ADDR_TXD, 32'h00000011);
        apb(1'b1, audio_port_pkg::ADDR_TXD, 32'h00000022);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'h0);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h0);
    endtask

    // Cycles between two toggles of the system (sel 0) or bit (sel 1) clock
    task automatic half(input logic sel, input logic [31:0] exp);
        logic last;
        int n;
        int k;
        k = 0;
        n = 0;
        last = sel ? bclk : mclk;
        while ((sel ? bclk : mclk) === last && k < 100) begin
            @(posedge clock);
            k++;
        end
        last = sel ? bclk : mclk;
        while ((sel ? bclk : mclk) === last && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (k >= 100 || n >= 100) timeout();
        check(32'(n), exp);
    endtask

    task automatic t_clk(input logic [31:0] cfg, input logic [31:0] me, input logic [31:0] be);
        apb(1'b1, audio_port_pkg::ADDR_CFG, cfg);
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'h00009000);
        half(1'b0, me);
        half(1'b1, be);
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'h0);
    endtask

    // Two words out, compared with what the codec captured
    task automatic t_tx(input logic [7:0] slot, input logic [7:0] depth, input logic left,
        input logic [31:0] wl, input logic [31:0] wr, input logic [31:0] el,
        input logic [31:0] er);
        logic [31:0] mask;
        int n;
        n = 0;
        do_reset();
        mask = (slot == 8'h20) ? 32'hffffffff : (32'h1 << slot) - 32'h1;
        apb(1'b1, audio_port_pkg::ADDR_TXD, wl);
        apb(1'b1, audio_port_pkg::ADDR_TXD, wr);
        apb(1'b1, audio_port_pkg::ADDR_CFG, {slot, depth, 8'h01, 8'h02});
        apb(1'b1, audio_port_pkg::ADDR_CTL, {16'h0, 1'b1, left, 6'h10, 1'b1, 7'h0});
        @(posedge clock);
        check({31'h0, tx_dma}, 32'h0);
        while (words !== 8'h03 && n < 3000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 3000) timeout();
        check(left_word & mask, el);
        check(right_word & mask, er);
        check({31'h0, tx_dma}, 32'h1);
    endtask

    // Reception with DMA request, then buffer order and empty read
    task automatic t_rx();
        logic [31:0] w0;
        int n;
        n = 0;
        do_reset();
        apb(1'b1, audio_port_pkg::ADDR_CFG, 32'h08080102);
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'h0000a800);
        while ((rx_dma !== 1'b1 || words !== 8'h06) && n < 3000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 3000) timeout();
        check({31'h0, rx_dma}, 32'h1);
        apb(1'b1, audio_port_pkg::ADDR_CTL, 32'h0);
        apb(1'b0, audio_port_pkg::ADDR_RXD, 32'h0);
        w0 = rd;
        apb(1'b0, audio_port_pkg::ADDR_RXD, 32'h0);
        check(w0, 32'h000000a5);
        check(rd, 32'h0000005a);
        apb(1'b0, audio_port_pkg::ADDR_RXD, 32'h0);
        check(rd, 32'h00000000);
    endtask

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        do_reset();
        t_regs();
        t_irq();
        t_clk(32'h08080102, 32'h3, 32'h2);
        t_clk(32'h08080300, 32'h1, 32'h4);
        t_tx(8'h08, 8'h08, 1'b0, 32'hc3, 32'h3c, 32'hc3, 32'h3c);
        t_tx(8'h10, 8'h08, 1'b1, 32'hc3, 32'h3c, 32'hc300, 32'h3c00);
        t_tx(8'h10, 8'h08, 1'b0, 32'hc3, 32'h3c, 32'h00c3, 32'h003c);
        t_tx(8'h08, 8'h10, 1'b1, 32'hc35a, 32'h3ca5, 32'hc3, 32'h3c);
        t_tx(8'h20, 8'h20, 1'b0, 32'h80000001, 32'h7ffffffe, 32'h80000001,
            32'h7ffffffe);
        t_rx();
        report_and_stop();
    end
endmodule
`default_nettype wire
